// ==== rtl/mise_exec.v ====
/*
  Execution unit for a subset of an 8-bit microcontroller instruction set:
  decrement/increment skips, fill, bit tests, subtract, nibble exchange,
  table fetch and exclusive-or.
  Assumes decode presents one operation per cycle with OP_VALID, the addressed
  data byte on MEM_RDATA in that cycle and the program word on PROG_WORD in
  that cycle (program memory addressed combinationally from PROG_ADDR).
*/
`include "mise_exec_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module mise_exec (
  // clock and reset
  input wire CLK,
  input wire SYS_RST,
  // decoded instruction
  input wire OP_VALID,
  input wire [4:0] OP,
  input wire [2:0] BIT_SEL,
  input wire [7:0] IMM,
  // data memory operand
  input wire [7:0] MEM_RDATA,
  // program memory for table fetch
  input wire [11:0] PC,
  input wire [7:0] TABLE_POINTER,
  output wire [11:0] PROG_ADDR,
  input wire [15:0] PROG_WORD,
  // data memory write back
  output reg MEM_WE,
  output reg [7:0] MEM_WDATA,
  // architectural state
  output wire [7:0] ACC,
  output wire [3:0] FLAGS,
  output wire [7:0] TABLE_HIGH_BYTE,
  // pipeline control
  output reg SKIP,
  output wire BUSY
);

  reg [7:0] acc_q;
  reg [7:0] acc_d;
  reg [3:0] flags_q;
  reg [3:0] flags_d;
  reg [7:0] thb_q;
  reg [7:0] thb_d;
  reg dummy_q;
  reg mem_we_d;
  reg [7:0] mem_wdata_d;
  reg skip_d;

  wire go;
  wire [7:0] inc_v;
  wire [7:0] dec_v;
  wire [7:0] swap_v;
  wire [7:0] sub_op;
  wire [8:0] sub_sum;
  wire [4:0] sub_lo;
  wire [7:0] sub_res;
  wire sub_ov;
  wire [7:0] bit_mask;
  wire sel_bit;
  genvar gi;

  // dummy cycle blocks a new operation
  assign go = OP_VALID & ~dummy_q;
  assign BUSY = dummy_q;

  assign inc_v = MEM_RDATA + 8'h01;
  assign dec_v = MEM_RDATA - 8'h01;
  assign swap_v = {MEM_RDATA[3:0], MEM_RDATA[7:4]};
  // one-hot mask of the selected bit
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_mask
      localparam [2:0] IDX = gi;
      assign bit_mask[gi] = (BIT_SEL == IDX);
    end
  endgenerate
  assign sel_bit = MEM_RDATA[BIT_SEL];

  // acc + ~operand + 1, carry set when no borrow
  assign sub_op = (OP == `MISE_OP_SUB_IMM) ? IMM : MEM_RDATA;
  assign sub_sum = {1'b0, acc_q} + {1'b0, ~sub_op} + 9'h001;
  assign sub_lo = {1'b0, acc_q[3:0]} + {1'b0, ~sub_op[3:0]} + 5'h01;
  assign sub_res = sub_sum[7:0];
  assign sub_ov = (acc_q[7] ^ sub_op[7]) & (acc_q[7] ^ sub_res[7]);

  // last page is the top page of program memory
  assign PROG_ADDR = (OP == `MISE_OP_TBL_LAST) ? {4'hf, TABLE_POINTER} :
                     {PC[11:8], TABLE_POINTER};

  assign ACC = acc_q;
  assign FLAGS = flags_q;
  assign TABLE_HIGH_BYTE = thb_q;

  always @* begin
    acc_d = acc_q;
    flags_d = flags_q;
    thb_d = thb_q;
    mem_we_d = 1'b0;
    mem_wdata_d = 8'h00;
    skip_d = 1'b0;
    if (go) begin
      case (OP)
        `MISE_OP_DECR_ACC_SKZ: begin
          acc_d = dec_v;
          skip_d = (dec_v == 8'h00);
        end
        `MISE_OP_FILL: begin
          mem_we_d = 1'b1;
          mem_wdata_d = `MISE_FILL_VAL;
        end
        `MISE_OP_FILL_BIT: begin
          mem_we_d = 1'b1;
          mem_wdata_d = MEM_RDATA | bit_mask;
        end
        `MISE_OP_INCR_SKZ: begin
          mem_we_d = 1'b1;
          mem_wdata_d = inc_v;
          skip_d = (inc_v == 8'h00);
        end
        `MISE_OP_INCR_ACC_SKZ: begin
          acc_d = inc_v;
          skip_d = (inc_v == 8'h00);
        end
        `MISE_OP_BIT_HI_SKIP: begin
          skip_d = sel_bit;
        end
        `MISE_OP_SUB_MEM, `MISE_OP_SUB_IMM, `MISE_OP_SUB_TO_MEM: begin
          if (OP == `MISE_OP_SUB_TO_MEM) begin
            mem_we_d = 1'b1;
            mem_wdata_d = sub_res;
          end else begin
            acc_d = sub_res;
          end
          flags_d[`MISE_FLG_C] = sub_sum[8];
          flags_d[`MISE_FLG_AC] = sub_lo[4];
          flags_d[`MISE_FLG_Z] = (sub_res == 8'h00);
          flags_d[`MISE_FLG_OV] = sub_ov;
        end
        `MISE_OP_NIB_XCHG: begin
          mem_we_d = 1'b1;
          mem_wdata_d = swap_v;
        end
        `MISE_OP_NIB_XCHG_ACC: begin
          acc_d = swap_v;
        end
        `MISE_OP_ZERO_SKIP: begin
          skip_d = (MEM_RDATA == 8'h00);
        end
        `MISE_OP_COPY_Z_SKIP: begin
          acc_d = MEM_RDATA;
          skip_d = (MEM_RDATA == 8'h00);
        end
        `MISE_OP_BIT_LO_SKIP: begin
          skip_d = ~sel_bit;
        end
        `MISE_OP_TBL_CUR, `MISE_OP_TBL_LAST: begin
          mem_we_d = 1'b1;
          mem_wdata_d = PROG_WORD[7:0];
          thb_d = PROG_WORD[15:8];
        end
        `MISE_OP_XOR_MEM: begin
          acc_d = acc_q ^ MEM_RDATA;
          flags_d[`MISE_FLG_Z] = ((acc_q ^ MEM_RDATA) == 8'h00);
        end
        `MISE_OP_XOR_TO_MEM: begin
          mem_we_d = 1'b1;
          mem_wdata_d = acc_q ^ MEM_RDATA;
          flags_d[`MISE_FLG_Z] = ((acc_q ^ MEM_RDATA) == 8'h00);
        end
        `MISE_OP_XOR_IMM: begin
          acc_d = acc_q ^ IMM;
          flags_d[`MISE_FLG_Z] = ((acc_q ^ IMM) == 8'h00);
        end
        default: begin
          acc_d = acc_q;
        end
      endcase
    end
  end

  always @(posedge CLK) begin
    if (SYS_RST) begin
      acc_q <= `MISE_ACC_RST;
      flags_q <= `MISE_FLAGS_RST;
      thb_q <= `MISE_THB_RST;
      dummy_q <= 1'b0;
      MEM_WE <= 1'b0;
      MEM_WDATA <= 8'h00;
      SKIP <= 1'b0;
    end else begin
      acc_q <= acc_d;
      flags_q <= flags_d;
      thb_q <= thb_d;
      // skip costs one dummy cycle: 2 cycles instead of 1
      dummy_q <= skip_d;
      MEM_WE <= mem_we_d;
      MEM_WDATA <= mem_wdata_d;
      SKIP <= skip_d;
    end
  end

endmodule // mise_exec

`default_nettype wire

// ==== rtl/mise_exec_regs.vh ====
/*
  Constants for the instruction subset execution unit: operation codes,
  flag bit positions, fill value, cycle counts.
  Assumes inclusion by bare name from the execution unit.
*/
`ifndef MISE_EXEC_REGS_VH
`define MISE_EXEC_REGS_VH

// operation codes on OP
`define MISE_OP_NOP        5'h00
`define MISE_OP_DECR_ACC_SKZ 5'h01
`define MISE_OP_FILL       5'h02
`define MISE_OP_FILL_BIT   5'h03
`define MISE_OP_INCR_SKZ   5'h04
`define MISE_OP_INCR_ACC_SKZ 5'h05
`define MISE_OP_BIT_HI_SKIP 5'h06
`define MISE_OP_SUB_MEM    5'h07
`define MISE_OP_SUB_IMM    5'h08
`define MISE_OP_SUB_TO_MEM 5'h09
`define MISE_OP_NIB_XCHG   5'h0a
`define MISE_OP_NIB_XCHG_ACC 5'h0b
`define MISE_OP_ZERO_SKIP  5'h0c
`define MISE_OP_COPY_Z_SKIP 5'h0d
`define MISE_OP_BIT_LO_SKIP 5'h0e
`define MISE_OP_TBL_CUR    5'h0f
`define MISE_OP_TBL_LAST   5'h10
`define MISE_OP_XOR_MEM    5'h11
`define MISE_OP_XOR_TO_MEM 5'h12
`define MISE_OP_XOR_IMM    5'h13

// flag bit positions in the 4-bit flag vector
`define MISE_FLG_C  0
`define MISE_FLG_AC 1
`define MISE_FLG_Z  2
`define MISE_FLG_OV 3

// values and cycle counts
`define MISE_FILL_VAL   8'hff
`define MISE_ACC_RST    8'h00
`define MISE_THB_RST    8'h00
`define MISE_FLAGS_RST  4'h0
`define MISE_CYC_NORMAL 2'd1
`define MISE_CYC_SKIP   2'd2

`endif

// ==== sim/mise_exec_asserts.sv ====
/*
  Port checker for mise_exec: skips, writes, flags and table fetch.
  Assumes bind onto mise_exec and mise_exec_regs.vh on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mise_exec_regs.vh"
module mise_exec_asserts (
  // clock, reset, request
  input wire logic CLK, SYS_RST, OP_VALID,
  input wire logic [4:0] OP,
  input wire logic [2:0] BIT_SEL,
  input wire logic [7:0] IMM, MEM_RDATA, TABLE_POINTER,
  input wire logic [11:0] PC, PROG_ADDR,
  input wire logic [15:0] PROG_WORD,
  // results
  input wire logic MEM_WE, SKIP, BUSY,
  input wire logic [7:0] MEM_WDATA, ACC, TABLE_HIGH_BYTE,
  input wire logic [3:0] FLAGS
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  wire go = OP_VALID && !BUSY;
  // skip pulse, then dummy cycle over
  sequence skip_pulse;
    SKIP && BUSY ##1 !SKIP && !BUSY;
  endsequence
  chk_decr_acc: assert property (go && OP == `MISE_OP_DECR_ACC_SKZ |=>
    ACC == $past(MEM_RDATA) - 8'h01 && !MEM_WE) else $error("decr to acc wrong");
  chk_fill_ones: assert property (go && OP == `MISE_OP_FILL |=>
    MEM_WE && MEM_WDATA == 8'hff && $stable(FLAGS)) else $error("fill wrong");
  chk_fill_bit: assert property (go && OP == `MISE_OP_FILL_BIT |=> MEM_WE &&
    MEM_WDATA == ($past(MEM_RDATA) | (8'h01 << $past(BIT_SEL)))) else $error("bit fill wrong");
  chk_incr_wrap: assert property (go && OP == `MISE_OP_INCR_SKZ && MEM_RDATA == 8'hff
    |=> skip_pulse) else $error("incr skip missing");
  chk_sub_carry: assert property (go && OP == `MISE_OP_SUB_MEM |=>
    FLAGS[0] == ($past(ACC) >= $past(MEM_RDATA))) else $error("sub carry wrong");
  chk_zero_skip: assert property (go && OP == `MISE_OP_ZERO_SKIP |=>
    SKIP == ($past(MEM_RDATA) == 8'h00) && !MEM_WE) else $error("zero skip wrong");
  chk_table_last: assert property (go && OP == `MISE_OP_TBL_LAST |->
    PROG_ADDR == {4'hf, TABLE_POINTER} ##1 {TABLE_HIGH_BYTE, MEM_WDATA} == $past(PROG_WORD))
    else $error("last page fetch wrong");
  chk_xor_imm: assert property (go && OP == `MISE_OP_XOR_IMM |=>
    ACC == ($past(ACC) ^ $past(IMM)) && (FLAGS & 4'hb) == ($past(FLAGS) & 4'hb)
    && FLAGS[2] == (ACC == 8'h00)) else $error("xor imm wrong");
  chk_busy_hold: assert property (BUSY |=> !MEM_WE && !SKIP && $stable(ACC))
    else $error("op taken in dummy cycle");
endmodule // mise_exec_asserts
bind mise_exec mise_exec_asserts u_chk (.CLK(CLK), .SYS_RST(SYS_RST), .OP_VALID(OP_VALID),
  .OP(OP), .BIT_SEL(BIT_SEL), .IMM(IMM), .MEM_RDATA(MEM_RDATA), .TABLE_POINTER(TABLE_POINTER),
  .PC(PC), .PROG_ADDR(PROG_ADDR), .PROG_WORD(PROG_WORD), .MEM_WE(MEM_WE), .SKIP(SKIP),
  .BUSY(BUSY), .MEM_WDATA(MEM_WDATA), .ACC(ACC), .TABLE_HIGH_BYTE(TABLE_HIGH_BYTE),
  .FLAGS(FLAGS));
`default_nettype wire

// ==== sim/mise_exec_bench.sv ====
/*
  Self-checking bench for mise_exec: row table, then table fetch,
  dummy cycle and mid-run reset.
  Assumes mise_exec_regs.vh on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mise_exec_regs.vh"
module mise_exec_bench;
  logic clk = 1'b0, rst = 1'b1, ov = 1'b0;
  logic [4:0] op = 5'h00;
  logic [2:0] bs = 3'h0;
  logic [7:0] imm = 8'h00, md = 8'h00, tp = 8'h44;
  logic [11:0] pc = 12'h3a0;
  wire [11:0] pa;
  wire [15:0] pw = {pa[11:4], pa[7:0]};
  wire we, skp, bsy;
  wire [7:0] wd, acc, tbh;
  wire [3:0] flg;
  int mismatches = 0, n_checks = 0;
  // op b mem imm acc wdata flags {we,skip}
  logic [51:0] rows [0:25] = '{
    52'h01_0_01_00_00_00_01,
    52'h01_0_05_00_04_00_00,
    52'h02_0_12_00_04_ff_02,
    52'h03_3_10_00_04_18_02,
    52'h04_0_ff_00_04_00_03,
    52'h04_0_7f_00_04_80_02,
    52'h05_0_ff_00_00_00_01,
    52'h06_7_80_00_00_00_01,
    52'h13_0_00_05_05_00_00,
    52'h07_0_03_00_02_00_30,
    52'h08_0_00_03_ff_00_00,
    52'h09_0_7f_00_ff_80_32,
    52'h08_0_00_ff_00_00_70,
    52'h13_0_00_80_80_00_30,
    52'h08_0_00_01_7f_00_90,
    52'h0a_0_a5_00_7f_5a_92,
    52'h0b_0_c3_00_3c_00_90,
    52'h0c_0_00_00_3c_00_91,
    52'h0c_0_01_00_3c_00_90,
    52'h0d_0_44_00_44_00_90,
    52'h0d_0_00_00_00_00_91,
    52'h0e_0_fe_00_00_00_91,
    52'h11_0_00_00_00_00_d0,
    52'h12_0_5a_00_00_5a_92,
    52'h06_7_7f_00_00_00_90,
    52'h0e_1_02_00_00_00_90};
  always #25 clk = ~clk;
  mise_exec u_dut (.CLK(clk), .SYS_RST(rst), .OP_VALID(ov), .OP(op), .BIT_SEL(bs), .IMM(imm),
    .MEM_RDATA(md), .PC(pc), .TABLE_POINTER(tp), .PROG_ADDR(pa), .PROG_WORD(pw),
    .MEM_WE(we), .MEM_WDATA(wd), .ACC(acc), .FLAGS(flg), .TABLE_HIGH_BYTE(tbh),
    .SKIP(skp), .BUSY(bsy));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic run(input logic [51:0] r);
    @(posedge clk);
    ov <= 1'b1;
    op <= r[48:44];
    bs <= r[42:40];
    md <= r[39:32];
    imm <= r[31:24];
    @(posedge clk);
    ov <= 1'b0;
    #1 chk({acc, wd, flg, we, skp, bsy}, {r[23:4], r[1:0], r[0]});
    if (r[0]) @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1 chk({acc, wd, flg, we, skp, bsy, tbh}, 32'h0);
    for (int k = 0; k < 26; k++) run(rows[k]);
    $display("row table done");
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      ov <= 1'b1;
      op <= k ? `MISE_OP_TBL_LAST : `MISE_OP_TBL_CUR;
      #1 chk(pa, k ? 12'hf44 : 12'h344);
      @(posedge clk);
      ov <= 1'b0;
      #1 chk({tbh, wd, we}, {k ? 8'hf4 : 8'h34, 8'h44, 1'b1});
    end
    $display("table fetch done");
    @(posedge clk);
    ov <= 1'b1;
    op <= `MISE_OP_INCR_SKZ;
    md <= 8'hff;
    @(posedge clk);
    op <= `MISE_OP_FILL;
    #1 chk({skp, bsy, we, wd}, {3'h7, 8'h00});
    @(posedge clk);
    ov <= 1'b0;
    #1 chk({skp, bsy, we, wd}, 11'h0);
    $display("dummy cycle done");
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1 chk({acc, flg, tbh, we}, 21'h0);
    run(rows[1]);
    $display("mid-run reset done");
    wrap_up();
  end
endmodule // mise_exec_bench
`default_nettype wire
